// ### logic/cam_diag.v
// camera diagnostics, status indicator and pixel controls behind axi4-lite
// ****************************************
// ****************************************
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "cam_diag_regs.vh"

module cam_diag #(
  parameter PW        = 16,
  parameter SEC_CYC   = `SECOND_CYC,
  parameter BLINK_CYC = `BLINK_CYC
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // axi4-lite write
  input  wire [11:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read
  input  wire [11:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // camera events and states
  input  wire          power_cycle,
  input  wire          bus_reset,
  input  wire          arb_fail,
  input  wire          fifo_ovf,
  input  wire          link_err,
  input  wire          fpga_init,
  input  wire          sensor_pd,
  input  wire          acquiring,
  input  wire          reg_access,
  input  wire          fw_update,
  input  wire          temp_fault,
  input  wire          serious_fault,
  // message log writes
  input  wire          log_wr,
  input  wire [7:0]    log_byte,
  // pixel stream
  input  wire          binning,
  input  wire          full_res,
  input  wire          pix_valid,
  input  wire [PW-1:0] pix_data,
  input  wire [PW-1:0] pix_left,
  input  wire [PW-1:0] pix_right,
  input  wire          pix_defect,
  input  wire          pix_tap,
  input  wire [11:0]   pix_col,
  input  wire [11:0]   pix_row,
  output wire          fifo_valid,
  output wire [PW-1:0] fifo_data,
  // outputs
  output reg  [1:0]    led_green,
  output reg  [1:0]    led_red,
  output reg           link_renegotiate,
  output reg           irq
);

  // ****************************************
  // state
  // ****************************************
  reg [2:0]  ctrl_r;
  reg [31:0] sec_div_r;
  reg [31:0] blink_div_r;
  reg        blink_r;
  reg [31:0] time_init_r;
  reg [31:0] time_bus_r;
  reg [31:0] tx_fail_r;
  reg [31:0] link_rec_r;
  reg [15:0] link_err_r;
  reg [15:0] link_thr_r;
  reg [3:0]  irq_stat_r;
  reg [3:0]  irq_mask_r;
  reg [7:0]  log_ptr_r;
  reg [15:0] gain0_r;
  reg [15:0] gain1_r;
  reg [7:0]  log_mem [0:255];

  reg        aw_hold_r;
  reg        w_hold_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;

  wire       sec_tick = (sec_div_r == SEC_CYC - 1);
  wire       do_wr    = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire       thr_hit  = link_err && (link_err_r + 16'h0001 >= link_thr_r);
  reg  [3:0] irq_ev;
  reg  [3:0] irq_clr;
  reg  [31:0] rd_word;
  reg        rd_ok;

  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [31:0] sat_inc;
    input [31:0] v;
    begin
      sat_inc = (v == 32'hffffffff) ? v : v + 32'h00000001;
    end
  endfunction

  function wr_hit;
    input [11:0] a;
    input [9:0]  off;
    begin
      wr_hit = (a[11:10] == 2'h0) && (a[9:2] == off[9:2]);
    end
  endfunction

  // ****************************************
  // time base and counters
  // ****************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_div_r   <= 32'h00000000;
      blink_div_r <= 32'h00000000;
      blink_r     <= 1'b0;
      time_init_r <= 32'h00000000;
      time_bus_r  <= 32'h00000000;
      tx_fail_r   <= 32'h00000000;
      link_rec_r  <= 32'h00000000;
      link_err_r  <= 16'h0000;
      link_renegotiate <= 1'b0;
    end
    else if (ce)
    begin
      sec_div_r <= sec_tick ? 32'h00000000 : sec_div_r + 32'h00000001;
      if (blink_div_r == BLINK_CYC - 1)
      begin
        blink_div_r <= 32'h00000000;
        blink_r     <= ~blink_r;
      end
      else
        blink_div_r <= blink_div_r + 32'h00000001;
      if (sec_tick)
        time_init_r <= sat_inc(time_init_r);
      if (bus_reset)
        time_bus_r <= 32'h00000000;
      else if (sec_tick)
        time_bus_r <= sat_inc(time_bus_r);
      if (arb_fail && fifo_ovf)
        tx_fail_r <= sat_inc(tx_fail_r);
      link_renegotiate <= thr_hit;
      if (thr_hit)
      begin
        link_err_r <= 16'h0000;
        link_rec_r <= sat_inc(link_rec_r);
      end
      else if (link_err)
        link_err_r <= link_err_r + 16'h0001;
    end
  end

  // ****************************************
  // message log
  // ****************************************
  // circular byte log
  always @(posedge aclk)
  begin
    if (ce && log_wr)
      log_mem[log_ptr_r] <= log_byte;
  end

  // ****************************************
  // axi4-lite write
  // ****************************************
  always @*
  begin
    irq_ev = 4'h0;
    irq_ev[`IRQ_TX_FAIL]   = arb_fail && fifo_ovf;
    irq_ev[`IRQ_LINK_REC]  = thr_hit;
    irq_ev[`IRQ_BUS_RESET] = bus_reset;
    irq_ev[`IRQ_LOG_WRAP]  = log_wr && (log_ptr_r == 8'hff);
    irq_clr = 4'h0;
    if (do_wr && wr_hit(awaddr_r, `REG_IRQ_STAT) && wstrb_r[0])
      irq_clr = wdata_r[3:0];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CTRL_RST;
      link_thr_r    <= `LINK_THR_RST;
      irq_mask_r    <= 4'h0;
      irq_stat_r    <= 4'h0;
      log_ptr_r     <= 8'h00;
      gain0_r       <= `TAP_GAIN_RST;
      gain1_r       <= `TAP_GAIN_RST;
      irq           <= 1'b0;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (wr_hit(awaddr_r, `REG_CTRL) && wstrb_r[0])
        begin
          ctrl_r[`CTRL_LED_OFF]   <= ctrl_r[`CTRL_LED_OFF] | wdata_r[`CTRL_LED_OFF];
          ctrl_r[`CTRL_TPAT_EN]   <= wdata_r[`CTRL_TPAT_EN];
          ctrl_r[`CTRL_DEFECT_EN] <= wdata_r[`CTRL_DEFECT_EN];
        end
        else if (wr_hit(awaddr_r, `REG_LINK_THR))
          link_thr_r <= merge(link_thr_r, wdata_r[15:0], wstrb_r[1:0]);
        else if (wr_hit(awaddr_r, `REG_IRQ_MASK) && wstrb_r[0])
          irq_mask_r <= wdata_r[3:0];
        else if (wr_hit(awaddr_r, `REG_TAP_GAIN0))
          gain0_r <= merge(gain0_r, wdata_r[15:0], wstrb_r[1:0]);
        else if (wr_hit(awaddr_r, `REG_TAP_GAIN1))
          gain1_r <= merge(gain1_r, wdata_r[15:0], wstrb_r[1:0]);
        else if (!(wr_hit(awaddr_r, `REG_IRQ_STAT) || wr_hit(awaddr_r, `REG_LOG_PTR)))
          s_axi_bresp <= (awaddr_r[11:10] == `LOG_BASE_SEL) ? 2'h0 : 2'h2;
      end
      if (power_cycle)
        ctrl_r[`CTRL_LED_OFF] <= 1'b0;
      if (log_wr)
        log_ptr_r <= log_ptr_r + 8'h01;
      // set wins over clear
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************
  // axi4-lite read
  // ****************************************
  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    if (s_axi_araddr[11:10] == `LOG_BASE_SEL)
      rd_word = {log_mem[{s_axi_araddr[7:2], 2'h3}], log_mem[{s_axi_araddr[7:2], 2'h2}],
                 log_mem[{s_axi_araddr[7:2], 2'h1}], log_mem[{s_axi_araddr[7:2], 2'h0}]};
    else if (s_axi_araddr[11:10] != 2'h0)
      rd_ok = 1'b0;
    else
      case ({s_axi_araddr[9:2], 2'h0})
        `REG_CTRL:      rd_word = {29'h0, ctrl_r};
        `REG_STATE:     rd_word = {20'h0, led_red, led_green, serious_fault, temp_fault,
                                   fw_update, reg_access, acquiring, sensor_pd, fpga_init, blink_r};
        `REG_TIME_INIT: rd_word = time_init_r;
        `REG_TIME_BUS:  rd_word = time_bus_r;
        `REG_TX_FAIL:   rd_word = tx_fail_r;
        `REG_LINK_REC:  rd_word = link_rec_r;
        `REG_LINK_THR:  rd_word = {16'h0, link_thr_r};
        `REG_IRQ_STAT:  rd_word = {28'h0, irq_stat_r};
        `REG_IRQ_MASK:  rd_word = {28'h0, irq_mask_r};
        `REG_LOG_PTR:   rd_word = {24'h0, log_ptr_r};
        `REG_TAP_GAIN0: rd_word = {16'h0, gain0_r};
        `REG_TAP_GAIN1: rd_word = {16'h0, gain1_r};
        default:        rd_ok   = 1'b0;
      endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // status indicator
  // ****************************************
  // faults outrank activity, activity outranks idle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_green <= `LVL_OFF;
      led_red   <= `LVL_OFF;
    end
    else if (ce)
    begin
      led_green <= `LVL_ON;
      led_red   <= `LVL_OFF;
      if (ctrl_r[`CTRL_LED_OFF])
        led_green <= `LVL_OFF;
      else if (serious_fault)
      begin
        led_green <= `LVL_OFF;
        led_red   <= `LVL_ON;
      end
      else if (temp_fault)
      begin
        led_green <= `LVL_OFF;
        led_red   <= blink_r ? `LVL_ON : `LVL_OFF;
      end
      else if (fw_update)
      begin
        led_green <= blink_r ? `LVL_OFF : `LVL_ON;
        led_red   <= blink_r ? `LVL_ON : `LVL_OFF;
      end
      else if (fpga_init)
      begin
        led_green <= blink_r ? `LVL_ON : `LVL_OFF;
        led_red   <= blink_r ? `LVL_ON : `LVL_OFF;
      end
      else if (sensor_pd)
        led_red <= `LVL_DIM;
      else if (acquiring)
        led_green <= `LVL_BRIGHT;
      else if (reg_access)
        led_green <= blink_r ? `LVL_BRIGHT : `LVL_ON;
    end
  end

  // ****************************************
  // pixel path
  // ****************************************
  pix_path #(
    .PW        (PW)
  ) u_pix (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .defect_en (ctrl_r[`CTRL_DEFECT_EN]),
    .tpat_en   (ctrl_r[`CTRL_TPAT_EN]),
    .binning   (binning),
    .full_res  (full_res),
    .gain0     (gain0_r),
    .gain1     (gain1_r),
    .in_valid  (pix_valid),
    .in_data   (pix_data),
    .in_left   (pix_left),
    .in_right  (pix_right),
    .in_defect (pix_defect),
    .in_tap    (pix_tap),
    .in_col    (pix_col),
    .in_row    (pix_row),
    .out_valid (fifo_valid),
    .out_data  (fifo_data)
  );

endmodule // cam_diag

// ### logic/cam_diag_regs.vh
// register map, fields, reset values and timing for the camera diagnostics block
`ifndef CAM_DIAG_REGS_VH
`define CAM_DIAG_REGS_VH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS  4
`define SECOND_NS      1000000000
`define SECOND_CYC     (`SECOND_NS / `CLK_PERIOD_NS)
`define BLINK_CYC      (`SECOND_CYC / 4)

// ****************************************
// register byte offsets
// ****************************************
`define REG_CTRL       10'h000
`define REG_STATE      10'h004
`define REG_TIME_INIT  10'h008
`define REG_TIME_BUS   10'h00c
`define REG_TX_FAIL    10'h010
`define REG_LINK_REC   10'h014
`define REG_LINK_THR   10'h018
`define REG_IRQ_STAT   10'h01c
`define REG_IRQ_MASK   10'h020
`define REG_LOG_PTR    10'h024
`define REG_TAP_GAIN0  10'h028
`define REG_TAP_GAIN1  10'h02c
`define LOG_BASE_SEL   2'h1

// ****************************************
// fields and reset values
// ****************************************
`define CTRL_LED_OFF   0
`define CTRL_TPAT_EN   1
`define CTRL_DEFECT_EN 2
`define CTRL_RST       3'h4
`define IRQ_TX_FAIL    0
`define IRQ_LINK_REC   1
`define IRQ_BUS_RESET  2
`define IRQ_LOG_WRAP   3
`define LINK_THR_RST   16'h0010
`define TAP_GAIN_RST   16'h0100

// ****************************************
// indicator levels
// ****************************************
`define LVL_OFF        2'h0
`define LVL_DIM        2'h1
`define LVL_ON         2'h2
`define LVL_BRIGHT     2'h3

`endif

// ### logic/pix_path.v
// pixel path ahead of the image fifo: defect fix, tap balance, test pattern
`include "cam_diag_regs.vh"

module pix_path #(
  parameter PW = 16
) (
  // clock
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // control
  input  wire          defect_en,
  input  wire          tpat_en,
  input  wire          binning,
  input  wire          full_res,
  input  wire [15:0]   gain0,
  input  wire [15:0]   gain1,
  // pixel in
  input  wire          in_valid,
  input  wire [PW-1:0] in_data,
  input  wire [PW-1:0] in_left,
  input  wire [PW-1:0] in_right,
  input  wire          in_defect,
  input  wire          in_tap,
  input  wire [11:0]   in_col,
  input  wire [11:0]   in_row,
  // pixel out
  output reg           out_valid,
  output reg  [PW-1:0] out_data
);

  reg [PW-1:0] fixed;
  reg [PW:0]   pair_sum;
  reg [15:0]   gain;
  reg [PW+15:0] prod;
  reg [PW-1:0] bal;
  reg [PW-1:0] pat;

  always @*
  begin
    fixed    = in_data;
    pair_sum = {1'b0, in_left} + {1'b0, in_right};
    if (defect_en && in_defect && !binning)
      fixed = pair_sum[PW:1];
    gain = in_tap ? gain1 : gain0;
    prod = fixed * gain;
    bal = full_res ? prod[PW+7:8] : fixed;
    // static pattern, independent of imaging settings
    // pattern fills the low 16 bits, so pixel width must be at least 16
    pat       = {PW{1'b0}};
    pat[15:0] = {in_row[7:0] ^ in_col[7:0], in_col[7:0]};
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid <= 1'b0;
      out_data  <= {PW{1'b0}};
    end
    else if (ce)
    begin
      out_valid <= in_valid;
      out_data  <= tpat_en ? pat : bal;
    end
  end

endmodule // pix_path

// ### dv/cam_diag_properties.sv
// concurrent checks on the camera diagnostics top ports
module cam_diag_properties (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  input wire       ce,
  // register bus
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  // camera side
  input wire       pix_valid,
  input wire       fifo_valid,
  input wire       serious_fault,
  input wire [1:0] led_green,
  input wire [1:0] led_red,
  input wire       link_renegotiate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // properties
  // ****************************************
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  AST_AW_DROP: assert property (ce && s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stayed high after take");
  AST_WR_RESP: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  AST_RD_RESP: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_FIFO_LAT: assert property (ce && pix_valid |=> fifo_valid)
    else $error("pixel not passed to fifo");
  AST_RENEG_PULSE: assert property (ce && link_renegotiate |=> !link_renegotiate)
    else $error("renegotiate longer than one cycle");
  AST_SERIOUS_GREEN: assert property (serious_fault [*2] |-> led_green == 2'h0)
    else $error("green lit during serious fault");
  AST_SERIOUS_STEADY: assert property (serious_fault [*4] |-> $stable(led_red))
    else $error("red not steady during serious fault");
endmodule // cam_diag_properties

bind cam_diag cam_diag_properties cam_diag_properties_i (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pix_valid(pix_valid), .fifo_valid(fifo_valid),
  .serious_fault(serious_fault), .led_green(led_green), .led_red(led_red), .link_renegotiate(link_renegotiate));

// ### dv/host_link_model.sv
// host side of the link: error bursts, bus resets, recovery tally
module host_link_model (
  // clock
  input  wire aclk,
  // link
  input  wire link_renegotiate,
  output reg  link_err,
  output reg  bus_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  int recov;
  initial
  begin
    link_err = 0;
    bus_reset = 0;
    recov = 0;
  end
  always @(posedge aclk)
    if (link_renegotiate)
      recov <= recov + 1;
  task errors(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      link_err <= 1'b1;
      @(posedge aclk);
      link_err <= 1'b0;
    end
  endtask
  task reset_pulse;
    @(posedge aclk);
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
  endtask
endmodule // host_link_model

// ### dv/cam_diag_tb.sv
// self-checking bench for the camera diagnostics block
`include "cam_diag_regs.vh"
module cam_diag_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short second keeps the run brief
  localparam SEC = 200;
  // per indicator state, which level bits change over half a blink period
  localparam [23:0] FLIP = 24'h8a100a;
  reg         aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, power_cycle;
  reg         arb_fail, fifo_ovf, log_wr, binning, full_res, pix_valid, pix_defect, pix_tap;
  reg  [11:0] awaddr, araddr, pix_col, pix_row;
  reg  [31:0] wdata, d;
  reg  [1:0]  r, b;
  reg  [3:0]  g;
  reg  [6:0]  st;
  reg  [7:0]  log_byte;
  reg  [15:0] pix_data, pix_left, pix_right;
  wire        awready, wready, bvalid, arready, rvalid, fifo_valid, link_err, bus_reset, reneg, irq;
  wire [1:0]  bresp, rresp, led_green, led_red;
  wire [31:0] rdata;
  wire [15:0] fifo_data;
  int         err_total, check_count, i;

  cam_diag #(.PW(16), .SEC_CYC(SEC), .BLINK_CYC(4)) cam_diag_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_cycle(power_cycle),
    .bus_reset(bus_reset), .arb_fail(arb_fail), .fifo_ovf(fifo_ovf), .link_err(link_err),
    .fpga_init(st[0]), .sensor_pd(st[1]), .acquiring(st[2]), .reg_access(st[3]), .fw_update(st[4]),
    .temp_fault(st[5]), .serious_fault(st[6]), .log_wr(log_wr), .log_byte(log_byte), .binning(binning),
    .full_res(full_res), .pix_valid(pix_valid), .pix_data(pix_data), .pix_left(pix_left),
    .pix_right(pix_right), .pix_defect(pix_defect), .pix_tap(pix_tap), .pix_col(pix_col), .pix_row(pix_row),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .led_green(led_green), .led_red(led_red),
    .link_renegotiate(reneg), .irq(irq));
  host_link_model host_link_model_i (.aclk(aclk), .link_renegotiate(reneg), .link_err(link_err),
    .bus_reset(bus_reset));

  // ****************************************
  // tasks
  // ****************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // address and data go out together, each released when taken
  task wr(input [11:0] a, input [31:0] v);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready)
      begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    b = bresp;
    bready <= 0;
  endtask
  task rc(input [11:0] a, input [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
    chk($sformatf("reg %h", a), d, e);
  endtask
  task pix(input [15:0] v, l, rr, input df, tp, input [15:0] e);
    @(posedge aclk);
    pix_valid <= 1;
    pix_data <= v;
    pix_left <= l;
    pix_right <= rr;
    pix_defect <= df;
    pix_tap <= tp;
    @(posedge aclk);
    pix_valid <= 0;
    #1 chk("pixel", fifo_data, e);
  endtask

  initial
  begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    #20000 err_total++;
    report_and_stop;
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, power_cycle, arb_fail, fifo_ovf, log_wr} = 0;
    {binning, full_res, pix_valid, pix_defect, pix_tap, st, log_byte, awaddr, araddr, wdata} = 0;
    {pix_data, pix_left, pix_right} = 0;
    ce = 1;
    pix_col = 12'h005;
    pix_row = 12'h003;
    wt(16);
    aresetn <= 1;
    wt(450);
    rc(`REG_TIME_INIT, 32'h2);
    rc(`REG_TIME_BUS, 32'h2);
    host_link_model_i.reset_pulse();
    rc(`REG_TIME_BUS, 32'h0);
    rc(`REG_TIME_INIT, 32'h2);
    rc(`REG_CTRL, `CTRL_RST);
    rc(`REG_TX_FAIL, 32'h0);
    rc(`REG_TAP_GAIN0, `TAP_GAIN_RST);
    rc(12'h300, 32'h0);
    chk("resp", r, 32'h2);
    wr(12'h300, 32'h0);
    chk("wresp", b, 32'h2);
    $display("seconds and reset values done");
    arb_fail <= 1;
    wt(3);
    fifo_ovf <= 1;
    wt(3);
    arb_fail <= 0;
    wt(2);
    fifo_ovf <= 0;
    rc(`REG_TX_FAIL, 32'h3);
    // frozen clock enable must not count a failure
    ce <= 0;
    arb_fail <= 1;
    fifo_ovf <= 1;
    wt(3);
    {arb_fail, fifo_ovf} <= 2'h0;
    ce <= 1;
    rc(`REG_TX_FAIL, 32'h3);
    wr(`REG_IRQ_MASK, 32'h1);
    chk("wresp", b, 32'h0);
    wt(2);
    chk("irq", irq, 32'h1);
    rc(`REG_IRQ_STAT, 32'h5);
    wr(`REG_IRQ_STAT, 32'h1);
    wt(2);
    chk("irq", irq, 32'h0);
    $display("transmit failure done");
    for (i = 0; i < 4; i++)
    begin
      @(posedge aclk);
      log_wr <= 1;
      log_byte <= 8'h11 * (i + 1);
    end
    @(posedge aclk);
    log_wr <= 0;
    rc(`REG_LOG_PTR, 32'h4);
    rc(12'h400, 32'h44332211);
    wr(`REG_LINK_THR, 32'h3);
    host_link_model_i.errors(3);
    wt(4);
    rc(`REG_LINK_REC, 32'h1);
    chk("recoveries", host_link_model_i.recov, 32'h1);
    $display("log and link done");
    pix(16'h0040, 16'h0010, 16'h0020, 1, 0, 16'h0018);
    @(posedge aclk);
    binning <= 1;
    pix(16'h0040, 16'h0010, 16'h0020, 1, 0, 16'h0040);
    @(posedge aclk);
    binning <= 0;
    full_res <= 1;
    wr(`REG_TAP_GAIN0, 32'h200);
    pix(16'h0040, 16'h0, 16'h0, 0, 0, 16'h0080);
    pix(16'h0040, 16'h0, 16'h0, 0, 1, 16'h0040);
    @(posedge aclk);
    full_res <= 0;
    pix(16'h0040, 16'h0, 16'h0, 0, 0, 16'h0040);
    wr(`REG_CTRL, 32'h0);
    pix(16'h0040, 16'h0010, 16'h0020, 1, 0, 16'h0040);
    wr(`REG_CTRL, 32'h2);
    pix(16'h0040, 16'h0010, 16'h0020, 1, 0, 16'h0605);
    $display("pixel path done");
    wr(`REG_CTRL, 32'h4);
    wt(3);
    chk("green", led_green, `LVL_ON);
    chk("red", led_red, `LVL_OFF);
    st <= 7'h04;
    wt(3);
    chk("green", led_green, `LVL_BRIGHT);
    st <= 7'h40;
    wt(6);
    chk("red", led_red, `LVL_ON);
    chk("green", led_green, `LVL_OFF);
    for (i = 0; i < 6; i++)
    begin
      st <= 7'h01 << i;
      wt(8);
      g = {led_red, led_green};
      wt(4);
      if (i == 1)
        chk("yellow-green", {led_red, led_green}, 4'h6);
      if (i < 3)
        chk("flash", g ^ {led_red, led_green}, FLIP[i*4 +: 4]);
      else
        chk("flash", g ^ {led_red, led_green}, FLIP[i*4 +: 4]);
    end
    st <= 0;
    wr(`REG_CTRL, 32'h1);
    wt(3);
    chk("green", led_green, `LVL_OFF);
    wr(`REG_CTRL, 32'h0);
    wt(3);
    chk("green", led_green, `LVL_OFF);
    @(posedge aclk);
    power_cycle <= 1;
    @(posedge aclk);
    power_cycle <= 0;
    wt(3);
    chk("green", led_green, `LVL_ON);
    $display("indicator done");
    report_and_stop;
  end
endmodule // cam_diag_tb
